// ===== include/irq_halt_pkg.sv
// constants, types and register map of the interrupt and halt controller
package irq_halt_pkg;

  // ==========================================================================
  // register indexes (byte address = 4 * index)
  localparam logic [15:0] prog_timer_irq_enable_idx = 16'hffe2;
  localparam logic [15:0] serial_irq_enable_idx = 16'hffe3;
  localparam logic [15:0] key_input_irq_enable_idx = 16'hffe4;
  localparam logic [15:0] clock_timer_irq_enable_idx = 16'hffe6;
  localparam logic [15:0] stopwatch_irq_enable_idx = 16'hffe7;
  localparam logic [15:0] prog_timer_event_flags_idx = 16'hfff2;
  localparam logic [15:0] serial_event_flag_idx = 16'hfff3;
  localparam logic [15:0] key_input_event_flag_idx = 16'hfff4;
  localparam logic [15:0] clock_timer_event_flags_idx = 16'hfff6;
  localparam logic [15:0] stopwatch_event_flags_idx = 16'hfff7;
  localparam logic [15:0] core_control_idx = 16'hff00;
  localparam logic [15:0] irq_status_idx = 16'hff01;
  localparam logic [15:0] irq_enable_idx = 16'hff02;
  localparam logic [15:0] irq_clear_idx = 16'hff03;
  localparam logic [15:0] vector_status_idx = 16'hff04;

  // ==========================================================================
  // source groups, highest maskable priority first
  localparam int n_groups = 5;
  localparam logic [2:0] grp_prog = 3'h0;
  localparam logic [2:0] grp_serial = 3'h1;
  localparam logic [2:0] grp_key = 3'h2;
  localparam logic [2:0] grp_clock = 3'h3;
  localparam logic [2:0] grp_stopwatch = 3'h4;

  // implemented bits of each mask/flag nibble; the rest read zero
  localparam logic [3:0] bits_prog = 4'h3;
  localparam logic [3:0] bits_serial = 4'h1;
  localparam logic [3:0] bits_key = 4'h1;
  localparam logic [3:0] bits_clock = 4'hf;
  localparam logic [3:0] bits_stopwatch = 4'h3;
  localparam logic [3:0] nibble_reset = 4'h0;

  // ==========================================================================
  // vectors
  localparam logic [15:0] vector_page = 16'h0100;
  localparam logic [3:0] vec_watchdog = 4'h0;
  localparam logic [3:0] vec_prog = 4'h4;
  localparam logic [3:0] vec_serial = 4'h6;
  localparam logic [3:0] vec_key = 4'h8;
  localparam logic [3:0] vec_clock = 4'hc;
  localparam logic [3:0] vec_stopwatch = 4'he;

  // ==========================================================================
  // core control fields and status-register events
  localparam int ctl_iflag_bit = 0;
  localparam int ctl_unblocked_bit = 1;
  localparam int ctl_halted_bit = 2;
  localparam int ctl_busy_bit = 3;
  localparam int ev_accept_bit = 0;
  localparam int ev_nmi_bit = 1;
  localparam int ev_wake_bit = 2;
  localparam int n_events = 3;
  localparam logic [2:0] events_reset = 3'h0;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_save_flags = 4'b0010,
    st_push_pc = 4'b0100,
    st_load_vector = 4'b1000
  } accept_state_t;

endpackage : irq_halt_pkg

// ===== verilog/irq_halt_ctrl.sv
// interrupt and halt controller of a 4-bit microcontroller, apb register slave
// ============================================================================
// Summary of operation
// - maskable request needs global flag and mask
// - acceptance clears the global enable flag
// - watchdog request ignores flag and masks
// - after reset block all until both pointers
// - single pointer write blocks all until partner
// - halt stops cpu, timers keep counting
// - only a request that is taken ends halt
// - flags set by their own source events
// - clock taps set flags on falling edge
// - writing one clears an event flag
// - reset clears every event flag
// - uncleared flag requests again when re-enabled
// - masks read/write, one enables, reset zero
// - one mask bit per flag, same position
// - accept only at instruction boundary
// - save flags, push pc, load vector
// - fixed priority and vectors, watchdog highest
// - request supplies four low vector bits
`timescale 1ns/1ps
`default_nettype none

module irq_halt_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral events
  input wire logic [1:0] prog_timer_zero,
  input wire logic serial_done,
  input wire logic key_port_edge,
  input wire logic [3:0] clk_tap_level,
  input wire logic [1:0] stopwatch_tick,
  input wire logic watchdog_request,
  // cpu core side
  input wire logic instr_done,
  input wire logic halt_exec,
  input wire logic return_from_interrupt,
  input wire logic enable_irq_exec,
  input wire logic disable_irq_exec,
  input wire logic first_stack_pointer_write,
  input wire logic second_stack_pointer_write,
  output logic cpu_run,
  output logic save_flags,
  output logic push_pc,
  output logic load_vector,
  output logic [3:0] vector_low,
  output logic [15:0] vector_addr,
  output logic irq
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [4:0][3:0] mask;
    logic [4:0][3:0] flag;
    logic [3:0] tap_prev;
    logic iflag;
    // pointer loads seen since the pair was last left incomplete
    logic sp1_ok;
    logic sp2_ok;
    logic halted;
    logic nmi_pending;
    irq_halt_pkg::accept_state_t acc;
    logic [3:0] vec;
    logic [2:0] ev_status;
    logic [2:0] ev_enable;
    logic [31:0] rdata;
  } state_t;

  state_t r;
  state_t next_r;

  // ==========================================================================
  // decode
  logic [15:0] idx;
  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic [3:0] rd_nibble;
  logic [4:0][3:0] valid_bits;
  logic [4:0] grp_req;
  logic any_maskable;
  logic unblocked;
  logic take_nmi;
  logic take_maskable;
  logic [3:0] sel_vec;
  logic [4:0][3:0] set_flags;
  // acceptance and halt control
  logic busy;
  logic accept_now;
  logic wake_req;
  logic [3:0] tap_fell;

  assign idx = paddr[17:2];
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = setup && !pwrite;

  always_comb begin
    valid_bits[irq_halt_pkg::grp_prog] = irq_halt_pkg::bits_prog;
    valid_bits[irq_halt_pkg::grp_serial] = irq_halt_pkg::bits_serial;
    valid_bits[irq_halt_pkg::grp_key] = irq_halt_pkg::bits_key;
    valid_bits[irq_halt_pkg::grp_clock] = irq_halt_pkg::bits_clock;
    valid_bits[irq_halt_pkg::grp_stopwatch] = irq_halt_pkg::bits_stopwatch;
  end

  // source events mapped into flag nibbles
  always_comb begin
    set_flags = '0;
    set_flags[irq_halt_pkg::grp_prog][1:0] = prog_timer_zero;
    set_flags[irq_halt_pkg::grp_serial][0] = serial_done;
    set_flags[irq_halt_pkg::grp_key][0] = key_port_edge;
    set_flags[irq_halt_pkg::grp_clock] = tap_fell;
    set_flags[irq_halt_pkg::grp_stopwatch][1:0] = stopwatch_tick;
  end

  // per-group request: or of enabled flags, same bit position
  always_comb begin
    for (int g = 0; g < irq_halt_pkg::n_groups; g++) begin
      grp_req[g] = |(r.flag[g] & r.mask[g]);
    end
  end

  assign any_maskable = r.iflag && (|grp_req);
  assign unblocked = r.sp1_ok && r.sp2_ok;
  // halted counts as a boundary: no instruction is in flight
  assign take_nmi = unblocked && r.nmi_pending;
  assign take_maskable = unblocked && any_maskable;
  assign busy = (r.acc != irq_halt_pkg::st_idle);
  // a new entry starts only from idle, at an instruction end or in halt
  assign accept_now = !busy && (instr_done || r.halted)
    && (take_nmi || take_maskable);
  assign wake_req = r.halted && (take_nmi || take_maskable);
  // taps are divided clock levels; only a high-to-low step is an event
  assign tap_fell = r.tap_prev & ~clk_tap_level;

  // fixed priority select
  always_comb begin
    if (r.nmi_pending) begin
      sel_vec = irq_halt_pkg::vec_watchdog;
    end else if (grp_req[irq_halt_pkg::grp_prog]) begin
      sel_vec = irq_halt_pkg::vec_prog;
    end else if (grp_req[irq_halt_pkg::grp_serial]) begin
      sel_vec = irq_halt_pkg::vec_serial;
    end else if (grp_req[irq_halt_pkg::grp_key]) begin
      sel_vec = irq_halt_pkg::vec_key;
    end else if (grp_req[irq_halt_pkg::grp_clock]) begin
      sel_vec = irq_halt_pkg::vec_clock;
    end else begin
      sel_vec = irq_halt_pkg::vec_stopwatch;
    end
  end

  // address map lookup for read data and slave error
  always_comb begin
    mapped = 1'b1;
    rd_nibble = 4'h0;
    if (idx == irq_halt_pkg::prog_timer_irq_enable_idx) begin
      rd_nibble = r.mask[irq_halt_pkg::grp_prog];
    end else if (idx == irq_halt_pkg::serial_irq_enable_idx) begin
      rd_nibble = r.mask[irq_halt_pkg::grp_serial];
    end else if (idx == irq_halt_pkg::key_input_irq_enable_idx) begin
      rd_nibble = r.mask[irq_halt_pkg::grp_key];
    end else if (idx == irq_halt_pkg::clock_timer_irq_enable_idx) begin
      rd_nibble = r.mask[irq_halt_pkg::grp_clock];
    end else if (idx == irq_halt_pkg::stopwatch_irq_enable_idx) begin
      rd_nibble = r.mask[irq_halt_pkg::grp_stopwatch];
    end else if (idx == irq_halt_pkg::prog_timer_event_flags_idx) begin
      rd_nibble = r.flag[irq_halt_pkg::grp_prog];
    end else if (idx == irq_halt_pkg::serial_event_flag_idx) begin
      rd_nibble = r.flag[irq_halt_pkg::grp_serial];
    end else if (idx == irq_halt_pkg::key_input_event_flag_idx) begin
      rd_nibble = r.flag[irq_halt_pkg::grp_key];
    end else if (idx == irq_halt_pkg::clock_timer_event_flags_idx) begin
      rd_nibble = r.flag[irq_halt_pkg::grp_clock];
    end else if (idx == irq_halt_pkg::stopwatch_event_flags_idx) begin
      rd_nibble = r.flag[irq_halt_pkg::grp_stopwatch];
    end else if (idx == irq_halt_pkg::core_control_idx) begin
      rd_nibble[irq_halt_pkg::ctl_iflag_bit] = r.iflag;
      rd_nibble[irq_halt_pkg::ctl_unblocked_bit] = unblocked;
      rd_nibble[irq_halt_pkg::ctl_halted_bit] = r.halted;
      rd_nibble[irq_halt_pkg::ctl_busy_bit] = busy;
    end else if (idx == irq_halt_pkg::irq_status_idx) begin
      rd_nibble = {1'b0, r.ev_status};
    end else if (idx == irq_halt_pkg::irq_enable_idx) begin
      rd_nibble = {1'b0, r.ev_enable};
    end else if (idx == irq_halt_pkg::irq_clear_idx) begin
      rd_nibble = 4'h0; // write-only
    end else if (idx == irq_halt_pkg::vector_status_idx) begin
      rd_nibble = r.vec;
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    logic [4:0][3:0] w1c;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic sp1_w;
    logic sp2_w;
    w1c = '0;
    ev_set = '0;
    ev_clr = '0;
    sp1_w = first_stack_pointer_write;
    sp2_w = second_stack_pointer_write;
    next_r = r;
    next_r.tap_prev = clk_tap_level;

    // apb writes, taken at the access edge
    if (wr) begin
      if (idx == irq_halt_pkg::prog_timer_irq_enable_idx) begin
        next_r.mask[irq_halt_pkg::grp_prog] = pwdata[3:0] & irq_halt_pkg::bits_prog;
      end else if (idx == irq_halt_pkg::serial_irq_enable_idx) begin
        next_r.mask[irq_halt_pkg::grp_serial] = pwdata[3:0] & irq_halt_pkg::bits_serial;
      end else if (idx == irq_halt_pkg::key_input_irq_enable_idx) begin
        next_r.mask[irq_halt_pkg::grp_key] = pwdata[3:0] & irq_halt_pkg::bits_key;
      end else if (idx == irq_halt_pkg::clock_timer_irq_enable_idx) begin
        next_r.mask[irq_halt_pkg::grp_clock] = pwdata[3:0] & irq_halt_pkg::bits_clock;
      end else if (idx == irq_halt_pkg::stopwatch_irq_enable_idx) begin
        next_r.mask[irq_halt_pkg::grp_stopwatch] =
          pwdata[3:0] & irq_halt_pkg::bits_stopwatch;
      end else if (idx == irq_halt_pkg::prog_timer_event_flags_idx) begin
        w1c[irq_halt_pkg::grp_prog] = pwdata[3:0];
      end else if (idx == irq_halt_pkg::serial_event_flag_idx) begin
        w1c[irq_halt_pkg::grp_serial] = pwdata[3:0];
      end else if (idx == irq_halt_pkg::key_input_event_flag_idx) begin
        w1c[irq_halt_pkg::grp_key] = pwdata[3:0];
      end else if (idx == irq_halt_pkg::clock_timer_event_flags_idx) begin
        w1c[irq_halt_pkg::grp_clock] = pwdata[3:0];
      end else if (idx == irq_halt_pkg::stopwatch_event_flags_idx) begin
        w1c[irq_halt_pkg::grp_stopwatch] = pwdata[3:0];
      end else if (idx == irq_halt_pkg::core_control_idx) begin
        next_r.iflag = pwdata[irq_halt_pkg::ctl_iflag_bit];
      end else if (idx == irq_halt_pkg::irq_enable_idx) begin
        next_r.ev_enable = pwdata[irq_halt_pkg::n_events-1:0];
      end else if (idx == irq_halt_pkg::irq_clear_idx) begin
        ev_clr = pwdata[irq_halt_pkg::n_events-1:0];
      end
    end

    // cpu flag instructions; return_from_interrupt sets the enable flag, as enable_irq_exec does
    if (enable_irq_exec || return_from_interrupt) begin
      next_r.iflag = 1'b1;
    end else if (disable_irq_exec) begin
      next_r.iflag = 1'b0;
    end

    // a lone pointer write re-arms the block until its partner follows;
    // a pointer already loaded means the pair is being reloaded, so the
    // partner's earlier load no longer counts
    if (sp1_w && sp2_w) begin
      next_r.sp1_ok = 1'b1;
      next_r.sp2_ok = 1'b1;
    end else if (sp1_w) begin
      next_r.sp1_ok = 1'b1;
      next_r.sp2_ok = r.sp2_ok && !r.sp1_ok;
    end else if (sp2_w) begin
      next_r.sp2_ok = 1'b1;
      next_r.sp1_ok = r.sp1_ok && !r.sp2_ok;
    end

    // watchdog request held until taken; stopping the watchdog is its source's job
    if (watchdog_request) begin
      next_r.nmi_pending = 1'b1;
    end

    // acceptance sequence: one state per entry step, so the core does
    // each step while its strobe stands; no new entry until back in idle
    case (r.acc)
      irq_halt_pkg::st_idle: begin
        if (accept_now) begin
          next_r.vec = sel_vec;
          next_r.acc = irq_halt_pkg::st_save_flags;
          ev_set[irq_halt_pkg::ev_accept_bit] = 1'b1;
          if (take_nmi) begin
            // a fresh watchdog pulse in the taking cycle stays pending
            next_r.nmi_pending = watchdog_request;
            ev_set[irq_halt_pkg::ev_nmi_bit] = 1'b1;
          end
        end
      end
      irq_halt_pkg::st_save_flags: begin
        next_r.iflag = 1'b0;
        next_r.acc = irq_halt_pkg::st_push_pc;
      end
      irq_halt_pkg::st_push_pc: begin
        next_r.acc = irq_halt_pkg::st_load_vector;
      end
      irq_halt_pkg::st_load_vector: begin
        next_r.acc = irq_halt_pkg::st_idle;
      end
      default: begin
        next_r.acc = irq_halt_pkg::st_idle;
      end
    endcase

    // halt: cpu stops, event inputs keep being taken
    if (wake_req) begin
      next_r.halted = 1'b0;
      ev_set[irq_halt_pkg::ev_wake_bit] = 1'b1;
    end else if (halt_exec && !busy && !accept_now) begin
      // an entry taken at the halt boundary must run with the core awake
      next_r.halted = 1'b1;
    end

    // flags: source set wins over write-one clear
    for (int g = 0; g < irq_halt_pkg::n_groups; g++) begin
      next_r.flag[g] = ((r.flag[g] & ~w1c[g]) | set_flags[g]) & valid_bits[g];
    end
    next_r.ev_status = (r.ev_status & ~ev_clr) | ev_set;

    // read data captured in setup so it stands through the access phase
    if (rd) begin
      next_r.rdata = {28'h0000000, rd_nibble};
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.mask <= '0;
      r.flag <= '0;
      r.tap_prev <= 4'h0;
      r.iflag <= 1'b0;
      r.sp1_ok <= 1'b0;
      r.sp2_ok <= 1'b0;
      r.halted <= 1'b0;
      r.nmi_pending <= 1'b0;
      r.acc <= irq_halt_pkg::st_idle;
      r.vec <= irq_halt_pkg::vec_watchdog;
      r.ev_status <= irq_halt_pkg::events_reset;
      r.ev_enable <= irq_halt_pkg::events_reset;
      r.rdata <= 32'h00000000;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  // no wait states: every register answers in its access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = r.rdata;
  assign cpu_run = !r.halted;
  assign save_flags = (r.acc == irq_halt_pkg::st_save_flags);
  assign push_pc = (r.acc == irq_halt_pkg::st_push_pc);
  assign load_vector = (r.acc == irq_halt_pkg::st_load_vector);
  assign vector_low = r.vec;
  assign vector_addr = {irq_halt_pkg::vector_page[15:4], r.vec};
  // level output; software drops it through the clear register
  assign irq = |(r.ev_status & r.ev_enable);

endmodule : irq_halt_ctrl

`default_nettype wire

// ===== sim/irq_halt_ctrl_monitor.sv
// assertion checker for the interrupt and halt controller
`timescale 1ns/1ps
`default_nettype none

module irq_halt_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_done,
  input wire logic halt_exec,
  input wire logic watchdog_request,
  input wire logic first_stack_pointer_write,
  input wire logic second_stack_pointer_write,
  input wire logic cpu_run,
  input wire logic save_flags,
  input wire logic push_pc,
  input wire logic load_vector,
  input wire logic [3:0] vector_low,
  input wire logic [15:0] vector_addr
);
  // ==========================================================================
  // pointer pairing tracked apart from the design
  logic [1:0] sp;
  logic [1:0] next_sp;
  logic sp_ok;
  logic busy;
  always_comb begin
    next_sp = sp;
    if (first_stack_pointer_write && second_stack_pointer_write) next_sp = 2'h3;
    else if (first_stack_pointer_write) next_sp = (sp == 2'h2) ? 2'h3 : 2'h1;
    else if (second_stack_pointer_write) next_sp = (sp == 2'h1) ? 2'h3 : 2'h2;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sp <= 2'h0;
    else sp <= next_sp;
  end
  assign sp_ok = (sp == 2'h3);
  assign busy = save_flags | push_pc | load_vector;

  // ==========================================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_entry;
    save_flags ##1 push_pc ##1 load_vector;
  endsequence

  chk_entry_order: assert property (save_flags |-> seq_entry)
    else $error("acceptance strobes out of order");
  chk_vector_page: assert property (vector_addr == (16'h0100 | {12'h000, vector_low}))
    else $error("vector address outside vector page");
  chk_vector_legal: assert property (save_flags |-> vector_low inside {4'h0, 4'h4, 4'h6, 4'h8, 4'hc, 4'he})
    else $error("unknown vector selected");
  chk_pair_block: assert property (save_flags |-> $past(sp_ok))
    else $error("accepted before both pointers loaded");
  chk_instr_boundary: assert property (save_flags |-> $past(instr_done) || !$past(cpu_run))
    else $error("accepted mid instruction");
  chk_halt_cause: assert property ($fell(cpu_run) |-> $past(halt_exec))
    else $error("cpu stopped without halt");
  chk_wake_accept: assert property ($rose(cpu_run) |-> save_flags)
    else $error("wake without acceptance");
  chk_nmi_taken: assert property (watchdog_request && sp_ok && !busy |-> ##[1:12] save_flags)
    else $error("watchdog request not taken");
endmodule : irq_halt_ctrl_monitor

bind irq_halt_ctrl irq_halt_ctrl_monitor irq_halt_ctrl_monitor_inst (
  .pclk(pclk), .presetn(presetn), .instr_done(instr_done), .halt_exec(halt_exec),
  .watchdog_request(watchdog_request), .first_stack_pointer_write(first_stack_pointer_write),
  .second_stack_pointer_write(second_stack_pointer_write), .cpu_run(cpu_run),
  .save_flags(save_flags), .push_pc(push_pc), .load_vector(load_vector),
  .vector_low(vector_low), .vector_addr(vector_addr));
`default_nettype wire

// ===== sim/cpu_model.sv
// behavioural cpu core reporting instruction completions at a set pace
`timescale 1ns/1ps
`default_nettype none

module cpu_model #(
  parameter int gap = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_run,
  output logic instr_done
);
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 4'h0;
    else if (cnt == 4'(gap - 1)) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  // a halted core completes nothing
  assign instr_done = cpu_run && (cnt == 4'h0);
endmodule : cpu_model
`default_nettype wire

// ===== sim/testbench.sv
// self-checking testbench of the interrupt and halt controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, got;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] prog_timer_zero, stopwatch_tick;
  logic [3:0] clk_tap_level, vector_low;
  logic [15:0] vector_addr;
  logic serial_done, key_port_edge, watchdog_request, instr_done, halt_exec;
  logic return_from_interrupt, enable_irq_exec, disable_irq_exec;
  logic first_stack_pointer_write, second_stack_pointer_write;
  logic cpu_run, save_flags, push_pc, load_vector;
  logic [16:0] drv;
  int n_fail, checks;
  typedef struct {logic [15:0] m; logic [3:0] b; logic [3:0] v; logic [16:0] e;} row_t;
  row_t rows [5];

  assign {second_stack_pointer_write, first_stack_pointer_write, disable_irq_exec,
    enable_irq_exec, return_from_interrupt, halt_exec, watchdog_request, stopwatch_tick,
    clk_tap_level, key_port_edge, serial_done, prog_timer_zero} = drv;

  irq_halt_ctrl irq_halt_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_timer_zero(prog_timer_zero),
    .serial_done(serial_done), .key_port_edge(key_port_edge), .clk_tap_level(clk_tap_level),
    .stopwatch_tick(stopwatch_tick), .watchdog_request(watchdog_request),
    .instr_done(instr_done), .halt_exec(halt_exec),
    .return_from_interrupt(return_from_interrupt), .enable_irq_exec(enable_irq_exec),
    .disable_irq_exec(disable_irq_exec), .first_stack_pointer_write(first_stack_pointer_write),
    .second_stack_pointer_write(second_stack_pointer_write), .cpu_run(cpu_run),
    .save_flags(save_flags), .push_pc(push_pc), .load_vector(load_vector),
    .vector_low(vector_low), .vector_addr(vector_addr), .irq(irq));

  cpu_model #(.gap(3)) cpu_model_inst (.pclk(pclk), .presetn(presetn), .cpu_run(cpu_run),
    .instr_done(instr_done));

  // ==========================================================================
  // tasks
  task automatic summarize();
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] idx, input logic [3:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {28'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] e);
    apb(1'h0, idx, 4'h0);
    chk(rd, e);
  endtask : rdchk

  // one cycle of event pulses; clock taps fall when released
  task automatic ev(input logic [16:0] e);
    @(posedge pclk);
    drv <= e;
    @(posedge pclk);
    drv <= 17'h0;
  endtask : ev

  task automatic acc(input logic e, input logic [3:0] v);
    got = 1'h0;
    for (int i = 0; i < 16 && got !== 1'h1; i++) begin
      @(posedge pclk);
      #1;
      got = save_flags;
    end
    chk({31'h0, got}, {31'h0, e});
    if (e) begin
      chk({28'h0, vector_low}, {28'h0, v});
      chk({16'h0, vector_addr}, {16'h0, irq_halt_pkg::vector_page | {12'h0, v}});
    end
  endtask : acc

  task automatic irqchk(input logic [3:0] d, input logic [15:0] idx, input logic e);
    apb(1'h1, idx, d);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask : irqchk

  // ==========================================================================
  // clock, watchdog, sequence
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    #(50 * 20000);
    n_fail++;
    summarize();
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 18'h0;
    pwdata = 32'h0;
    drv = 17'h0;
    n_fail = 0;
    checks = 0;
    rows[0] = '{irq_halt_pkg::prog_timer_irq_enable_idx, 4'h3, irq_halt_pkg::vec_prog, 17'h3};
    rows[1] = '{irq_halt_pkg::serial_irq_enable_idx, 4'h1, irq_halt_pkg::vec_serial, 17'h4};
    rows[2] = '{irq_halt_pkg::key_input_irq_enable_idx, 4'h1, irq_halt_pkg::vec_key, 17'h8};
    rows[3] = '{irq_halt_pkg::clock_timer_irq_enable_idx, 4'hf, irq_halt_pkg::vec_clock, 17'hf0};
    rows[4] = '{irq_halt_pkg::stopwatch_irq_enable_idx, 4'h3, irq_halt_pkg::vec_stopwatch, 17'h300};
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    ev(17'h18000);
    foreach (rows[i]) begin
      rdchk(rows[i].m, 32'h0);
      rdchk(rows[i].m + 16'h10, 32'h0);
      apb(1'h1, rows[i].m, rows[i].b);
      rdchk(rows[i].m, {28'h0, rows[i].b});
      ev(rows[i].e);
      rdchk(rows[i].m + 16'h10, {28'h0, rows[i].b});
      acc(1'h0, 4'h0);
      apb(1'h1, irq_halt_pkg::core_control_idx, 4'h1);
      acc(1'h1, rows[i].v);
      apb(1'h0, irq_halt_pkg::core_control_idx, 4'h0);
      chk(rd & 32'h1, 32'h0);
      apb(1'h1, rows[i].m + 16'h10, 4'hf);
      rdchk(rows[i].m + 16'h10, 32'h0);
      apb(1'h1, rows[i].m, 4'h0);
    end
    // uncleared flag comes back, cleared one does not
    apb(1'h1, irq_halt_pkg::serial_irq_enable_idx, 4'h1);
    ev(17'h4);
    apb(1'h1, irq_halt_pkg::core_control_idx, 4'h1);
    acc(1'h1, irq_halt_pkg::vec_serial);
    ev(17'h1000);
    acc(1'h1, irq_halt_pkg::vec_serial);
    apb(1'h1, irq_halt_pkg::serial_event_flag_idx, 4'h1);
    ev(17'h2000);
    acc(1'h0, 4'h0);
    ev(17'h4000);
    ev(17'h4);
    acc(1'h0, 4'h0);
    // priority between pending sources
    apb(1'h1, irq_halt_pkg::key_input_irq_enable_idx, 4'h1);
    ev(17'h8);
    apb(1'h1, irq_halt_pkg::core_control_idx, 4'h1);
    acc(1'h1, irq_halt_pkg::vec_serial);
    apb(1'h1, irq_halt_pkg::serial_event_flag_idx, 4'h1);
    ev(17'h2000);
    acc(1'h1, irq_halt_pkg::vec_key);
    apb(1'h1, irq_halt_pkg::key_input_event_flag_idx, 4'h1);
    // halt and wake
    ev(17'h2800);
    repeat (4) @(posedge pclk);
    #1;
    chk({31'h0, cpu_run}, 32'h0);
    ev(17'h8);
    acc(1'h1, irq_halt_pkg::vec_key);
    chk({31'h0, cpu_run}, 32'h1);
    apb(1'h1, irq_halt_pkg::key_input_event_flag_idx, 4'h1);
    ev(17'h400);
    acc(1'h1, irq_halt_pkg::vec_watchdog);
    // interrupt output: masked, enabled, cleared
    irqchk(4'h0, irq_halt_pkg::irq_enable_idx, 1'h0);
    irqchk(4'h1, irq_halt_pkg::irq_enable_idx, 1'h1);
    irqchk(4'h7, irq_halt_pkg::irq_clear_idx, 1'h0);
    apb(1'h0, 16'h0000, 4'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // reset in mid-run, then pointer pairing
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(irq_halt_pkg::serial_irq_enable_idx, 32'h0);
    apb(1'h1, irq_halt_pkg::key_input_irq_enable_idx, 4'h1);
    apb(1'h1, irq_halt_pkg::core_control_idx, 4'h1);
    ev(17'h408);
    acc(1'h0, 4'h0);
    ev(17'h8000);
    acc(1'h0, 4'h0);
    ev(17'h10000);
    acc(1'h1, irq_halt_pkg::vec_watchdog);
    ev(17'h8000);
    apb(1'h1, irq_halt_pkg::core_control_idx, 4'h1);
    acc(1'h0, 4'h0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
